// *** hdl/emc_pkg.sv ***
// Shared constants of the memory error collector.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package emc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 20;
  localparam int TABLE_DEPTH = 16;

  // ----------------------------------------------------------------
  // Error classification by flipped-bit count
  // ----------------------------------------------------------------
  localparam logic [1:0] BITS_NONE   = 2'h0;
  localparam logic [1:0] BITS_SINGLE = 2'h1;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic RST_FLAG  = 1'h0;
  localparam logic RST_VALID = 1'h0;

endpackage

// *** hdl/emc_table.sv ***
// Reporting table store: address and class per entry, valid bits,
// registered read port and all entries laid out for parallel search.
// Assumes the parent supplies in-range indices.
module emc_table #(
  parameter int DEPTH  = emc_pkg::TABLE_DEPTH,
  parameter int ADDR_W = emc_pkg::ADDR_W,
  parameter int IDX_W  = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          srst,
  // Control
  input  wire logic                          clr,
  // Write port
  input  wire logic                          wr_en,
  input  wire logic [IDX_W-1:0]              wr_idx,
  input  wire logic [ADDR_W-1:0]             wr_addr,
  input  wire logic                          wr_unc,
  // Read port
  input  wire logic                          rd_en,
  input  wire logic [IDX_W-1:0]              rd_idx,
  output logic      [ADDR_W-1:0]             rd_addr,
  output logic                               rd_unc,
  output logic                               rd_used,
  // Search view
  output logic      [DEPTH-1:0]              ent_valid,
  output logic      [DEPTH-1:0][ADDR_W-1:0]  ent_addr
);

  typedef struct packed {
    logic [DEPTH-1:0]             valid;
    logic [DEPTH-1:0]             unc;
    logic [DEPTH-1:0][ADDR_W-1:0] addr;
    logic [ADDR_W-1:0]            rd_addr;
    logic                         rd_unc;
    logic                         rd_used;
  } emc_tbl_state_t;

  emc_tbl_state_t r_reg;
  emc_tbl_state_t r_next;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    if (wr_en) begin
      r_next.valid[wr_idx] = 1'h1;
      r_next.unc[wr_idx]   = wr_unc;
      r_next.addr[wr_idx]  = wr_addr;
    end
    if (clr) begin
      r_next.valid = '0;
    end
    if (rd_en) begin
      r_next.rd_addr = r_reg.addr[rd_idx];
      r_next.rd_unc  = r_reg.unc[rd_idx];
      r_next.rd_used = r_reg.valid[rd_idx];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rd_addr   = r_reg.rd_addr;
  assign rd_unc    = r_reg.rd_unc;
  assign rd_used   = r_reg.rd_used;
  assign ent_valid = r_reg.valid;
  assign ent_addr  = r_reg.addr;

endmodule

// *** hdl/emc_top.sv ***
// Memory error manager: collects SRAM ECC error events, records them in
// a reporting table and forwards reports to the fault collection unit.
// Assumes the ECC checkers present at most one event per cycle.
module emc_top #(
  parameter int DEPTH  = emc_pkg::TABLE_DEPTH,
  parameter int ADDR_W = emc_pkg::ADDR_W,
  parameter int IDX_W  = $clog2(DEPTH),
  parameter int CNT_W  = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // ECC checker events
  input  wire logic              err_valid,
  input  wire logic [ADDR_W-1:0] err_addr,
  input  wire logic [1:0]        err_bits,
  // Fault collection unit reports
  output logic                   fcu_corr,
  output logic                   fcu_uncorr,
  output logic      [ADDR_W-1:0] fcu_addr,
  // Record indication
  output logic                   rec_valid,
  output logic                   rec_unc,
  output logic                   rec_new,
  // Software preload
  input  wire logic              sw_wr_req,
  input  wire logic [ADDR_W-1:0] sw_wr_addr,
  input  wire logic              sw_wr_unc,
  output logic                   sw_wr_done,
  // Software table read
  input  wire logic              sw_rd_en,
  input  wire logic [IDX_W-1:0]  sw_rd_idx,
  output logic                   sw_rd_valid,
  output logic      [ADDR_W-1:0] sw_rd_addr,
  output logic                   sw_rd_unc,
  output logic                   sw_rd_used,
  // Table control and status
  input  wire logic              tbl_clear,
  output logic      [CNT_W-1:0]  tbl_count,
  output logic                   tbl_overflow
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (DEPTH < 2 || ADDR_W < 1 || IDX_W != $clog2(DEPTH) || CNT_W != $clog2(DEPTH + 1)) begin : g_bad_param
    $error("emc_top: unsupported parameter values");
  end

  typedef struct packed {
    logic              evt_v;
    logic [ADDR_W-1:0] evt_addr;
    logic              evt_unc;
    logic [CNT_W-1:0]  cnt;
    logic              ovf;
    logic              rep_c;
    logic              rep_u;
    logic [ADDR_W-1:0] rep_addr;
    logic              rec_v;
    logic              rec_unc;
    logic              rec_new;
    logic              sw_done;
    logic              rd_v;
  } emc_state_t;

  emc_state_t r_reg;
  emc_state_t r_next;

  logic [DEPTH-1:0]             ent_valid;
  logic [DEPTH-1:0][ADDR_W-1:0] ent_addr;
  logic [DEPTH-1:0]             match;
  logic                         hit;
  logic                         full;
  logic                         hw_wr;
  logic                         sw_go;
  logic                         wr_en;
  logic [ADDR_W-1:0]            wr_addr;
  logic                         wr_unc;

  // ----------------------------------------------------------------
  // Table search
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_cmp
    assign match[i] = ent_valid[i] && (ent_addr[i] == r_reg.evt_addr);
  end

  assign hit   = |match;
  assign full  = (r_reg.cnt == CNT_W'(DEPTH));
  assign hw_wr = r_reg.evt_v && !hit && !full;
  assign sw_go = sw_wr_req && !r_reg.sw_done && !r_reg.evt_v && !tbl_clear;
  assign wr_en = hw_wr || (sw_go && !full);
  assign wr_addr = hw_wr ? r_reg.evt_addr : sw_wr_addr;
  assign wr_unc  = hw_wr ? r_reg.evt_unc : sw_wr_unc;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next         = r_reg;
    r_next.rep_c   = 1'h0;
    r_next.rep_u   = 1'h0;
    r_next.rec_v   = 1'h0;
    r_next.sw_done = sw_go;
    r_next.rd_v    = sw_rd_en;
    // Capture stage
    r_next.evt_v    = err_valid && (err_bits != emc_pkg::BITS_NONE);
    r_next.evt_addr = err_addr;
    r_next.evt_unc  = (err_bits > emc_pkg::BITS_SINGLE);
    // Decision stage
    if (r_reg.evt_v) begin
      r_next.rec_v    = 1'h1;
      r_next.rec_unc  = r_reg.evt_unc;
      r_next.rec_new  = !hit;
      r_next.rep_addr = r_reg.evt_addr;
      if (r_reg.evt_unc) begin
        r_next.rep_u = 1'h1;
      end else begin
        r_next.rep_c = !hit;
      end
      if (!hit && full) begin
        r_next.ovf = 1'h1;
      end
    end
    if (sw_go && full) begin
      r_next.ovf = 1'h1;
    end
    if (wr_en) begin
      r_next.cnt = r_reg.cnt + CNT_W'(1);
    end
    if (tbl_clear) begin
      r_next.cnt = '0;
      r_next.ovf = emc_pkg::RST_FLAG;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Reporting table
  // ----------------------------------------------------------------
  emc_table #(
    .DEPTH  (DEPTH),
    .ADDR_W (ADDR_W),
    .IDX_W  (IDX_W)
  ) u_table (
    .clk       (clk),
    .srst      (srst),
    .clr       (tbl_clear),
    .wr_en     (wr_en),
    .wr_idx    (r_reg.cnt[IDX_W-1:0]),
    .wr_addr   (wr_addr),
    .wr_unc    (wr_unc),
    .rd_en     (sw_rd_en),
    .rd_idx    (sw_rd_idx),
    .rd_addr   (sw_rd_addr),
    .rd_unc    (sw_rd_unc),
    .rd_used   (sw_rd_used),
    .ent_valid (ent_valid),
    .ent_addr  (ent_addr)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign fcu_corr     = r_reg.rep_c;
  assign fcu_uncorr   = r_reg.rep_u;
  assign fcu_addr     = r_reg.rep_addr;
  assign rec_valid    = r_reg.rec_v;
  assign rec_unc      = r_reg.rec_unc;
  assign rec_new      = r_reg.rec_new;
  assign sw_wr_done   = r_reg.sw_done;
  assign sw_rd_valid  = r_reg.rd_v;
  assign tbl_count    = r_reg.cnt;
  assign tbl_overflow = r_reg.ovf;

endmodule

// *** bench/emc_monitor.sv ***
// Port checker of the memory error manager.
// Assumes a bind onto emc_top and one clock.
module emc_monitor #(
  parameter int ADDR_W = 20
) (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic              err_valid,
  input wire logic [ADDR_W-1:0] err_addr,
  input wire logic [1:0]        err_bits,
  input wire logic              fcu_corr,
  input wire logic              fcu_uncorr,
  input wire logic [ADDR_W-1:0] fcu_addr,
  input wire logic              rec_valid,
  input wire logic              rec_unc,
  input wire logic              rec_new,
  input wire logic              sw_wr_req,
  input wire logic              sw_wr_done,
  input wire logic              sw_rd_en,
  input wire logic              sw_rd_valid,
  input wire logic              tbl_clear,
  input wire logic              tbl_overflow
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // Event sequences
  // ----------------------------------------------------------------
  sequence s_err;
    err_valid && err_bits != 2'h0;
  endsequence
  sequence s_corr;
    err_valid && err_bits == 2'h1;
  endsequence
  sequence s_twice;
    s_corr ##1 (err_valid && err_bits == 2'h1 && err_addr == $past(err_addr) && !tbl_clear);
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_event_recorded: assert property (s_err |-> ##2 rec_valid) else $error("event not recorded");
  a_idle_quiet: assert property (!(err_valid && err_bits != 2'h0) |-> ##2 !rec_valid) else $error("stray record");
  a_addr_recorded: assert property (s_err |-> ##2 fcu_addr == $past(err_addr, 2)) else $error("wrong address");
  a_unc_reported: assert property (err_valid && err_bits[1] |-> ##2 fcu_uncorr && rec_unc) else $error("unc lost");
  a_corr_class: assert property (s_corr |-> ##2 !fcu_uncorr && !rec_unc) else $error("wrong class");
  a_corr_if_new: assert property (rec_valid && !rec_unc |-> fcu_corr == rec_new) else $error("corr report");
  a_repeat_silent: assert property (s_twice |-> ##2 (!fcu_corr || tbl_overflow)) else $error("repeat reported");
  a_read_answer: assert property (sw_rd_en |=> sw_rd_valid) else $error("read unanswered");
  a_preload_ack: assert property (sw_wr_done |-> $past(sw_wr_req)) else $error("stray done");
endmodule

bind emc_top emc_monitor #(.ADDR_W(ADDR_W)) i_emc_monitor (.clk(clk), .srst(srst), .err_valid(err_valid),
  .err_addr(err_addr), .err_bits(err_bits), .fcu_corr(fcu_corr), .fcu_uncorr(fcu_uncorr), .fcu_addr(fcu_addr),
  .rec_valid(rec_valid), .rec_unc(rec_unc), .rec_new(rec_new), .sw_wr_req(sw_wr_req), .sw_wr_done(sw_wr_done),
  .sw_rd_en(sw_rd_en), .sw_rd_valid(sw_rd_valid), .tbl_clear(tbl_clear), .tbl_overflow(tbl_overflow));

// *** bench/emc_ecc_src.sv ***
// Model of the SRAM ECC checkers that raise error events.
// Assumes send is entered shortly after a rising edge.
module emc_ecc_src (
  input  wire logic                  clk,
  output logic                       err_valid,
  output logic [emc_pkg::ADDR_W-1:0] err_addr,
  output logic [1:0]                 err_bits
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    err_valid = 1'h0;
    err_addr  = '0;
    err_bits  = 2'h0;
  end
  // One event per cycle for n cycles, then err_valid dropped and address and bits inverted
  task automatic send(input logic [emc_pkg::ADDR_W-1:0] addr, input logic [1:0] bits, input int n);
    err_valid = 1'h1;
    err_addr  = addr;
    err_bits  = bits;
    repeat (n) @(posedge clk);
    #1;
    err_valid = 1'h0;
    err_addr  = ~addr;
    err_bits  = ~bits;
  endtask
endmodule

// *** bench/emc_tb_top.sv ***
// Testbench of the memory error manager.
// Assumes emc_top with default sizes.
module emc_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                       clk = 1'h0;
  logic                       srst, err_valid, sw_wr_req, sw_wr_unc, sw_rd_en, tbl_clear;
  logic                       fcu_corr, fcu_uncorr, rec_valid, rec_unc, rec_new, sw_wr_done;
  logic                       sw_rd_valid, sw_rd_unc, sw_rd_used, tbl_overflow;
  logic [emc_pkg::ADDR_W-1:0] err_addr, sw_wr_addr, fcu_addr, sw_rd_addr;
  logic [1:0]                 err_bits;
  logic [3:0]                 sw_rd_idx;
  logic [4:0]                 tbl_count;
  int                         fails = 0, compares = 0, cyc = 0;

  always #5 clk = ~clk;
  emc_ecc_src i_emc_ecc_src (.clk(clk), .err_valid(err_valid), .err_addr(err_addr), .err_bits(err_bits));
  emc_top i_emc_top (.clk(clk), .srst(srst), .err_valid(err_valid), .err_addr(err_addr), .err_bits(err_bits),
    .fcu_corr(fcu_corr), .fcu_uncorr(fcu_uncorr), .fcu_addr(fcu_addr), .rec_valid(rec_valid), .rec_unc(rec_unc),
    .rec_new(rec_new), .sw_wr_req(sw_wr_req), .sw_wr_addr(sw_wr_addr), .sw_wr_unc(sw_wr_unc),
    .sw_wr_done(sw_wr_done), .sw_rd_en(sw_rd_en), .sw_rd_idx(sw_rd_idx), .sw_rd_valid(sw_rd_valid),
    .sw_rd_addr(sw_rd_addr), .sw_rd_unc(sw_rd_unc), .sw_rd_used(sw_rd_used), .tbl_clear(tbl_clear),
    .tbl_count(tbl_count), .tbl_overflow(tbl_overflow));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic ev(input logic [19:0] a, input logic [1:0] b, input int n);
    i_emc_ecc_src.send(a, b, n);
    tick();
  endtask
  task automatic rd(input logic [3:0] idx, input logic [19:0] a, input logic unc, input logic used);
    sw_rd_en  = 1'h1;
    sw_rd_idx = idx;
    tick();
    sw_rd_en  = 1'h0;
    chk("sw_rd_valid", 1, sw_rd_valid);
    chk("sw_rd_used", used, sw_rd_used);
    if (used) chk("sw_rd_addr", a, sw_rd_addr);
    if (used) chk("sw_rd_unc", unc, sw_rd_unc);
    tick();
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_corr;
    ev(20'h1a2b3, 2'h1, 1);
    chk("fcu_corr", 1, fcu_corr);
    chk("rec_new", 1, rec_new);
    chk("fcu_addr", 20'h1a2b3, fcu_addr);
    ev(20'h1a2b3, 2'h1, 1);
    chk("rec_valid", 1, rec_valid);
    chk("fcu_corr", 0, fcu_corr);
    ev(20'h3c3c3, 2'h1, 2);
    chk("rec_new", 0, rec_new);
    chk("tbl_count", 2, tbl_count);
    $display("test corr done");
  endtask
  task automatic t_unc;
    ev(20'h1a2b3, 2'h2, 1);
    chk("fcu_uncorr", 1, fcu_uncorr);
    chk("rec_unc", 1, rec_unc);
    ev(20'h00ff0, 2'h3, 1);
    chk("fcu_uncorr", 1, fcu_uncorr);
    chk("tbl_count", 3, tbl_count);
    ev(20'h00ff0, 2'h0, 1);
    chk("rec_valid", 0, rec_valid);
    $display("test unc done");
  endtask
  task automatic t_preload;
    sw_wr_addr = 20'h55aa5;
    sw_wr_unc  = 1'h1;
    sw_wr_req  = 1'h1;
    for (int i = 0; i < 8 && sw_wr_done !== 1'h1; i++) tick();
    sw_wr_req  = 1'h0;
    sw_wr_unc  = 1'h0;
    sw_wr_addr = 20'haa55a;
    chk("tbl_count", 4, tbl_count);
    ev(20'h55aa5, 2'h1, 1);
    chk("fcu_corr", 0, fcu_corr);
    chk("rec_valid", 1, rec_valid);
    $display("test preload done");
  endtask
  task automatic t_read;
    rd(4'h0, 20'h1a2b3, 1'h0, 1'h1);
    rd(4'h2, 20'h00ff0, 1'h1, 1'h1);
    rd(4'h3, 20'h55aa5, 1'h1, 1'h1);
    rd(4'h4, 20'h0, 1'h0, 1'h0);
    tbl_clear = 1'h1;
    tick();
    tbl_clear = 1'h0;
    chk("tbl_count", 0, tbl_count);
    rd(4'h0, 20'h0, 1'h0, 1'h0);
    $display("test read done");
  endtask
  task automatic t_full;
    for (int i = 0; i < 16; i++) begin
      ev(20'h40000 + 20'(i), 2'h1, 1);
    end
    chk("tbl_count", 16, tbl_count);
    chk("tbl_overflow", 0, tbl_overflow);
    ev(20'h7ffff, 2'h2, 1);
    chk("fcu_uncorr", 1, fcu_uncorr);
    chk("tbl_overflow", 1, tbl_overflow);
    chk("tbl_count", 16, tbl_count);
    rd(4'hf, 20'h4000f, 1'h0, 1'h1);
    tbl_clear = 1'h1;
    tick();
    tbl_clear = 1'h0;
    chk("tbl_overflow", 0, tbl_overflow);
    $display("test full done");
  endtask
  initial begin
    {srst, sw_wr_req, sw_wr_unc, sw_rd_en, tbl_clear} = 5'h10;
    sw_wr_addr = '0;
    sw_rd_idx  = '0;
    repeat (16) @(posedge clk);
    #1;
    srst = 1'h0;
    tick();
    chk("tbl_count", 0, tbl_count);
    t_corr();
    t_unc();
    t_preload();
    t_read();
    t_full();
    wrap_up();
  end
endmodule
